// ### src/cax_top.sv
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/100ps

module cax_top
   import cax_pkg::*;
(
   input  wire logic                  core_clk_i,
   input  wire logic                  nrst_i,
   input  wire cax_pkg::cax_avs_req_t avs_req_i,
   output cax_pkg::cax_avs_rsp_t      avs_rsp_o,
   input  wire logic                  cpu_idle_i,
   input  wire logic                  timer0_ovf_i,
   input  wire logic                  external_count_input_i,
   input  wire logic                  ext_clk_div8_i,
   input  wire logic [2:0]            module_pin_i,
   output logic [2:0]                 module_pin_o,
   output logic                       irq_o,
   output logic                       wdt_reset_o
);
   import cax_pkg::*;

   cax_state_t  r;
   cax_state_t  next_r;
   logic        halt;
   logic        running;
   logic        tb_tick;
   logic        cnt_inc;
   logic [15:0] cnt_nx;
   logic        lo_ovf;
   logic        hi_ovf;
   logic        wdog;
   logic        bus_acc;
   logic        bus_wr;
   logic        bus_rd;
   logic [7:0]  idx;
   logic [7:0]  wd;
   logic        wr_ctrl;
   logic        wr_mode;
   logic        wr_cnt_lo;
   logic        wr_cnt_hi;
   logic        wd_fire;
   logic [2:0]  evt_set;
   logic [2:0]  ecom_q;

   assign idx       = avs_req_i.address[9:2];
   assign wd        = avs_req_i.writedata[7:0];
   assign bus_acc   = (avs_req_i.read | avs_req_i.write) & ~r.rsp.waitrequest;
   assign bus_wr    = bus_acc & avs_req_i.write & avs_req_i.byteenable[0];
   assign bus_rd    = avs_req_i.read & r.rsp.waitrequest;
   assign wr_ctrl   = bus_wr & (idx == IDX_CTRL);
   assign wr_mode   = bus_wr & (idx == IDX_MODE);
   assign wr_cnt_lo = bus_wr & (idx == IDX_CNT_LO);
   assign wr_cnt_hi = bus_wr & (idx == IDX_CNT_HI);

   assign wdog    = r.mode[MODE_WATCHDOG_ENABLE];
   assign halt    = r.mode[MODE_IDLE] & cpu_idle_i;
   assign running = (r.run | wdog) & ~halt;

   // Timebase selection; the divided external clock is seen only after resync.
   assign tb_tick =
      (r.mode[MODE_TB_HI:MODE_TB_LO] == TB_DIV12)  ? (r.pre == PRE_LAST) :
      (r.mode[MODE_TB_HI:MODE_TB_LO] == TB_DIV4)   ? (r.pre[1:0] == PRE_Q4) :
      (r.mode[MODE_TB_HI:MODE_TB_LO] == TB_T0OVF)  ? timer0_ovf_i :
      (r.mode[MODE_TB_HI:MODE_TB_LO] == TB_EXTCNT) ?
         (r.eci_q & ~external_count_input_i) :
      (r.mode[MODE_TB_HI:MODE_TB_LO] == TB_SYSCLK) ? 1'b1 :
      (r.mode[MODE_TB_HI:MODE_TB_LO] == TB_EXTDIV) ? (r.ext_s2 & ~r.ext_q) :
      1'b0;

   assign cnt_inc = running & tb_tick;
   assign cnt_nx  = r.cnt + 16'h0001;
   assign lo_ovf  = cnt_inc & (r.cnt[7:0] == 8'hFF);
   assign hi_ovf  = cnt_inc & (r.cnt == 16'hFFFF);
   assign wd_fire = wdog & ((lo_ovf & (r.hi[2] == r.cnt[15:8]))
                    | (wr_ctrl & wd[2]));

   always_comb begin
      logic       mtch;
      logic       edge_ok;
      logic       sel8;
      logic       wdk;
      logic [7:0] m;
      next_r  = r;
      evt_set = 3'h0;
      mtch    = 1'b0;
      edge_ok = 1'b0;
      sel8    = 1'b0;
      wdk     = 1'b0;
      m       = 8'h00;

      next_r.ext_s1 = ext_clk_div8_i;
      next_r.ext_s2 = r.ext_s1;
      next_r.ext_q  = r.ext_s2;
      next_r.eci_q  = external_count_input_i;
      next_r.pin_q  = module_pin_i;
      next_r.pre    = (r.pre == PRE_LAST) ? 4'h0 : r.pre + 4'h1;

      if (cnt_inc) begin
         next_r.cnt = cnt_nx;
      end

      for (int k = 0; k < NUM_MODULES; k++) begin
         m    = r.mmode[k];
         wdk  = (k == 2) && wdog;
         sel8 = m[MM_PWM] & (~m[MM_P16] | m[MM_TOG]);
         mtch = cnt_inc & m[MM_ECOM] & ~wdk
                & (sel8 ? (cnt_nx[7:0] == r.lo[k]) : (cnt_nx == {r.hi[k], r.lo[k]}));
         if (mtch && m[MM_MAT]) begin
            evt_set[k] = 1'b1;
         end
         if (!wdk && m[MM_TOG]) begin
            if (mtch) begin
               next_r.pin_out[k] = ~r.pin_out[k];
               if (m[MM_PWM]) begin
                  next_r.lo[k] = r.lo[k] + r.hi[k];
               end
            end
         end else if (!wdk && m[MM_PWM]) begin
            if (mtch) begin
               next_r.pin_out[k] = 1'b1;
            end
            if (m[MM_P16] ? hi_ovf : lo_ovf) begin
               next_r.pin_out[k] = 1'b0;
            end
            if (!m[MM_P16] && lo_ovf) begin
               next_r.lo[k] = r.hi[k];
            end
         end
         edge_ok = (m[MM_CAPP] & module_pin_i[k] & ~r.pin_q[k])
                 | (m[MM_CAPN] & ~module_pin_i[k] & r.pin_q[k]);
         if (edge_ok && !wdk && !halt) begin
            next_r.lo[k] = r.cnt[7:0];
            next_r.hi[k] = r.cnt[15:8];
            evt_set[k]   = 1'b1;
         end

         if (bus_wr && idx == IDX_MMODE[k] && !wdk) begin
            next_r.mmode[k] = wd;
         end
         if (bus_wr && idx == IDX_MLO[k]) begin
            next_r.lo[k]              = wd;
            next_r.mmode[k][MM_ECOM]  = 1'b0;
         end
         if (bus_wr && idx == IDX_MHI[k]) begin
            if (wdk) begin
               next_r.hi[k] = r.cnt[15:8] + r.lo[k];
            end else begin
               next_r.hi[k]             = wd;
               next_r.mmode[k][MM_ECOM] = 1'b1;
            end
         end
      end

      if (wr_cnt_lo && !wdog) begin
         next_r.cnt[7:0] = wd;
      end
      if (wr_cnt_hi && !wdog) begin
         next_r.cnt[15:8] = wd;
      end

      // Software write first, then hardware sets, so an event never loses to a clear.
      if (wr_ctrl) begin
         next_r.ovf_flag = wd[CTRL_OVF];
         next_r.run      = wd[CTRL_RUN];
         next_r.evt      = wd[2:0];
      end
      next_r.ovf_flag = next_r.ovf_flag | hi_ovf;
      next_r.evt      = next_r.evt | evt_set;

      if (wr_mode) begin
         if (!wdog) begin
            next_r.mode = {wd[MODE_IDLE], wd[MODE_WATCHDOG_ENABLE] | wd[MODE_LOCK], wd[MODE_LOCK],
                           1'b0, wd[3:0]};
         end else begin
            next_r.mode[MODE_LOCK] = r.mode[MODE_LOCK] | wd[MODE_LOCK];
            next_r.mode[MODE_WATCHDOG_ENABLE] = r.mode[MODE_LOCK] | wd[MODE_LOCK]
                                   | wd[MODE_WATCHDOG_ENABLE];
         end
      end

      next_r.irq = (r.ovf_flag & r.mode[MODE_ECF])
                 | |(r.evt & ecom_q);
      next_r.wd_rst = wd_fire;

      next_r.rsp.waitrequest = ~((avs_req_i.read | avs_req_i.write) & r.rsp.waitrequest);
      next_r.rsp.readdata    = 32'h0000_0000;
      if (bus_rd) begin
         case (idx)
            IDX_CTRL: begin
               next_r.rsp.readdata[7:0] = {r.ovf_flag, r.run, 3'h0, r.evt};
            end
            IDX_MODE: begin
               next_r.rsp.readdata[7:0] = r.mode;
            end
            IDX_CNT_LO: begin
               next_r.rsp.readdata[7:0] = r.cnt[7:0];
            end
            IDX_CNT_HI: begin
               next_r.rsp.readdata[7:0] = r.cnt[15:8];
            end
            default: begin
               for (int k = 0; k < NUM_MODULES; k++) begin
                  if (idx == IDX_MMODE[k]) begin
                     next_r.rsp.readdata[7:0] = r.mmode[k];
                  end
                  if (idx == IDX_MLO[k]) begin
                     next_r.rsp.readdata[7:0] = r.lo[k];
                  end
                  if (idx == IDX_MHI[k]) begin
                     next_r.rsp.readdata[7:0] = r.hi[k];
                  end
               end
            end
         endcase
      end
   end

   // Per-module interrupt enable bits gathered for the request term.
   generate
      for (genvar g = 0; g < NUM_MODULES; g++) begin : g_ecc
         assign ecom_q[g] = r.mmode[g][MM_ECCF];
      end
   endgenerate

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         r                 <= '0;
         r.mode            <= MODE_RESET;
         r.rsp.waitrequest <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign avs_rsp_o    = r.rsp;
   assign module_pin_o = r.pin_out;
   assign irq_o        = r.irq;
   assign wdt_reset_o  = r.wd_rst;

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!nrst_i);

   property p_ovf_set;
      cnt_inc && r.cnt == 16'hFFFF |=> r.ovf_flag && r.cnt == 16'h0000;
   endproperty
   a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set on wrap");

   property p_stopped;
      !r.run && !wdog && !wr_cnt_lo && !wr_cnt_hi |=> r.cnt == $past(r.cnt);
   endproperty
   a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

   property p_flag_sticky;
      r.evt[0] && !wr_ctrl |=> r.evt[0];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("module flag lost");

   property p_ctrl_unused;
      bus_rd && idx == IDX_CTRL |=> avs_rsp_o.readdata[5:3] == 3'h0 && !avs_rsp_o.waitrequest;
   endproperty
   a_ctrl_unused: assert property (p_ctrl_unused) else $error("unused bits not zero");

   property p_idle_halt;
      halt && !wr_cnt_lo && !wr_cnt_hi |=> $stable(r.cnt);
   endproperty
   a_idle_halt: assert property (p_idle_halt) else $error("counter ran in idle");

   property p_lock;
      r.mode[MODE_LOCK] |=> r.mode[MODE_LOCK] && r.mode[MODE_WATCHDOG_ENABLE];
   endproperty
   a_lock: assert property (p_lock) else $error("locked watchdog was disabled");

   property p_ovf_irq;
      r.ovf_flag && r.mode[MODE_ECF] |=> irq_o;
   endproperty
   a_ovf_irq: assert property (p_ovf_irq) else $error("overflow interrupt missing");

   property p_mode_frozen;
      wdog && wr_mode |=> r.mode[MODE_IDLE] == $past(r.mode[MODE_IDLE])
                         && r.mode[3:0] == $past(r.mode[3:0]);
   endproperty
   a_mode_frozen: assert property (p_mode_frozen) else $error("mode not frozen");

   property p_lo_clr_ecom;
      bus_wr && idx == IDX_MLO[0] |=> !r.mmode[0][MM_ECOM]
         ##1 (!r.mmode[0][MM_ECOM] || $changed(r.mmode[0]));
   endproperty
   a_lo_clr_ecom: assert property (p_lo_clr_ecom) else $error("compare enable kept");

   property p_wd_reset;
      wdog && lo_ovf && r.hi[2] == r.cnt[15:8] |=> wdt_reset_o ##1 !wdt_reset_o || wd_fire;
   endproperty
   a_wd_reset: assert property (p_wd_reset) else $error("watchdog reset missing");

endmodule

// ### pkg/cax_pkg.sv
package cax_pkg;

   localparam int NUM_MODULES = 3;

   // Register indices; the Avalon byte address is four times the index.
   localparam logic [7:0] IDX_CTRL   = 8'hD8;
   localparam logic [7:0] IDX_MODE   = 8'hD9;
   localparam logic [7:0] IDX_CNT_LO = 8'hF9;
   localparam logic [7:0] IDX_CNT_HI = 8'hFA;
   localparam logic [2:0][7:0] IDX_MMODE = {8'hDC, 8'hDB, 8'hDA};
   localparam logic [2:0][7:0] IDX_MLO   = {8'hEB, 8'hE9, 8'hFB};
   localparam logic [2:0][7:0] IDX_MHI   = {8'hEC, 8'hEA, 8'hFC};

   // Control register fields.
   localparam int CTRL_OVF = 7;
   localparam int CTRL_RUN = 6;

   // Mode register fields.
   localparam int MODE_IDLE = 7;
   localparam int MODE_WATCHDOG_ENABLE = 6;
   localparam int MODE_LOCK = 5;
   localparam int MODE_UNUSED = 4;
   localparam int MODE_TB_HI = 3;
   localparam int MODE_TB_LO = 1;
   localparam int MODE_ECF  = 0;
   localparam logic [7:0] MODE_RESET = 8'h40;

   // Module mode fields.
   localparam int MM_P16  = 7;
   localparam int MM_ECOM = 6;
   localparam int MM_CAPP = 5;
   localparam int MM_CAPN = 4;
   localparam int MM_MAT  = 3;
   localparam int MM_TOG  = 2;
   localparam int MM_PWM  = 1;
   localparam int MM_ECCF = 0;

   // Timebase select codes.
   localparam logic [2:0] TB_DIV12  = 3'h0;
   localparam logic [2:0] TB_DIV4   = 3'h1;
   localparam logic [2:0] TB_T0OVF  = 3'h2;
   localparam logic [2:0] TB_EXTCNT = 3'h3;
   localparam logic [2:0] TB_SYSCLK = 3'h4;
   localparam logic [2:0] TB_EXTDIV = 3'h5;

   // Prescaler runs 0..PRE_LAST; every fourth count gives the divide-by-4 tick.
   localparam logic [3:0] PRE_LAST = 4'hB;
   localparam logic [1:0] PRE_Q4   = 2'h3;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [9:0]  address;
      logic [3:0]  byteenable;
      logic [31:0] writedata;
   } cax_avs_req_t;

   typedef struct packed {
      logic        waitrequest;
      logic [31:0] readdata;
   } cax_avs_rsp_t;

   typedef struct packed {
      logic            ovf_flag;
      logic            run;
      logic [2:0]      evt;
      logic [7:0]      mode;
      logic [2:0][7:0] mmode;
      logic [2:0][7:0] lo;
      logic [2:0][7:0] hi;
      logic [15:0]     cnt;
      logic [3:0]      pre;
      logic            eci_q;
      logic            ext_s1;
      logic            ext_s2;
      logic            ext_q;
      logic [2:0]      pin_q;
      logic [2:0]      pin_out;
      logic            irq;
      logic            wd_rst;
      cax_avs_rsp_t    rsp;
   } cax_state_t;

endpackage

// ### testbench/counter_array_regs_control_tb_top.sv
`timescale 1ns/100ps
module counter_array_regs_control_tb_top;
   import cax_pkg::*;
   logic         core_clk_i;
   logic         nrst_i;
   cax_avs_req_t avs_req_i;
   cax_avs_rsp_t avs_rsp_o;
   logic         cpu_idle_i;
   logic         timer0_ovf_i;
   logic         external_count_input_i;
   logic         ext_clk_div8_i;
   logic [2:0]   module_pin_i;
   logic [2:0]   module_pin_o;
   logic         irq_o;
   logic         wdt_reset_o;
   int           errors;
   int           comparisons;
   int           cyc;
   int           n;
   logic [7:0]   rdv;
   logic [7:0]   hv;
   int           tb_exp [6] = '{10, 30, 40, 15, 122, 12};

   cax_top u_dut (
      .core_clk_i            (core_clk_i),
      .nrst_i                (nrst_i),
      .avs_req_i             (avs_req_i),
      .avs_rsp_o             (avs_rsp_o),
      .cpu_idle_i            (cpu_idle_i),
      .timer0_ovf_i          (timer0_ovf_i),
      .external_count_input_i(external_count_input_i),
      .ext_clk_div8_i        (ext_clk_div8_i),
      .module_pin_i          (module_pin_i),
      .module_pin_o          (module_pin_o),
      .irq_o                 (irq_o),
      .wdt_reset_o           (wdt_reset_o)
   );

   initial begin
      core_clk_i = 1'b0;
      forever #50 core_clk_i = ~core_clk_i;
   end

   // Free-running timebase sources: timer pulse every 3, count input falls every 8 clocks.
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      timer0_ovf_i <= (cyc % 3 == 0);
      if (cyc % 4 == 0) external_count_input_i <= ~external_count_input_i;
      if (cyc % 5 == 0) ext_clk_div8_i <= ~ext_clk_div8_i;
   end

   task automatic final_report;
      $display("Comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic rng(input string name, input int lo, input int hi, input logic [15:0] got);
      comparisons++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         errors++;
         $display("[ERR] %s expected %0d..%0d seen %0d", name, lo, hi, got);
      end
   endtask

   // One Avalon access, entered just after a clock edge; read data lands in rdv.
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
      int k;
      k = 0;
      avs_req_i.read <= ~wr;
      avs_req_i.write <= wr;
      avs_req_i.address <= {idx, 2'b00};
      avs_req_i.writedata <= {24'h000000, d};
      do begin
         @(posedge core_clk_i);
         k++;
      end while (avs_rsp_o.waitrequest !== 1'b0 && k < 50);
      if (k >= 50) begin
         errors++;
         $display("[ERR] bus answer expected waitrequest low seen timeout");
      end
      rdv = avs_rsp_o.readdata[7:0];
      avs_req_i.read <= 1'b0;
      avs_req_i.write <= 1'b0;
      @(posedge core_clk_i);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask

   task automatic rc(input string name, input logic [7:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      chk(name, {8'h00, exp}, {8'h00, rdv});
   endtask

   task automatic tend(input string s);
      $display("Test %s done", s);
   endtask

   task automatic waitc(input int c);
      repeat (c) @(posedge core_clk_i);
   endtask

   initial begin
      waitc(60000);
      errors++;
      $display("[ERR] run expected finish seen timeout");
      final_report;
   end

   initial begin
      nrst_i = 1'b0;
      avs_req_i = '0;
      avs_req_i.byteenable = 4'hF;
      cpu_idle_i = 1'b0;
      timer0_ovf_i = 1'b0;
      external_count_input_i = 1'b1;
      ext_clk_div8_i = 1'b0;
      module_pin_i = 3'h0;
      cyc = 0;
      waitc(6);
      nrst_i <= 1'b1;
      @(posedge core_clk_i);
      rc("cnt_lo reset", IDX_CNT_LO, 8'h00);
      rc("ctrl reset", IDX_CTRL, 8'h00);
      rc("mode reset", IDX_MODE, MODE_RESET);
      for (int i = 0; i < 3; i++) rc("mmode reset", IDX_MMODE[i], 8'h00);
      rc("unmapped", 8'h00, 8'h00);
      wr(IDX_MODE, 8'h00);
      rc("wd off", IDX_MODE, 8'h00);
      wr(IDX_MODE, 8'h13);
      rc("mode bit4", IDX_MODE, 8'h03);
      wr(IDX_CTRL, 8'h38);
      rc("ctrl unused", IDX_CTRL, 8'h00);
      tend("registers");
      for (int i = 0; i < 6; i++) begin
         wr(IDX_MODE, {4'h0, i[2:0], 1'b0});
         wr(IDX_CNT_LO, 8'h00);
         wr(IDX_CTRL, 8'h40);
         waitc(120);
         wr(IDX_CTRL, 8'h00);
         bus(1'b0, IDX_CNT_LO, 8'h00);
         rng("timebase ticks", tb_exp[i] - 3, tb_exp[i] + 3, {8'h00, rdv});
      end
      tend("timebase");
      wr(IDX_CNT_LO, 8'h55);
      waitc(20);
      rc("stopped cnt", IDX_CNT_LO, 8'h55);
      wr(IDX_MODE, 8'h88);
      cpu_idle_i <= 1'b1;
      wr(IDX_CNT_LO, 8'h00);
      wr(IDX_CTRL, 8'h40);
      waitc(20);
      rc("idle halt", IDX_CNT_LO, 8'h00);
      cpu_idle_i <= 1'b0;
      waitc(20);
      bus(1'b0, IDX_CNT_LO, 8'h00);
      rng("idle resume", 20, 26, {8'h00, rdv});
      wr(IDX_CTRL, 8'h00);
      tend("idle");
      wr(IDX_MODE, 8'h09);
      wr(IDX_CNT_HI, 8'hFF);
      wr(IDX_CNT_LO, 8'hF0);
      wr(IDX_CTRL, 8'h40);
      waitc(40);
      rc("ovf flag", IDX_CTRL, 8'hC0);
      chk("ovf irq", 16'h0001, {15'h0, irq_o});
      wr(IDX_MODE, 8'h08);
      waitc(2);
      chk("ovf irq masked", 16'h0000, {15'h0, irq_o});
      wr(IDX_CTRL, 8'h00);
      rc("ovf clear", IDX_CTRL, 8'h00);
      tend("overflow");
      wr(IDX_CNT_HI, 8'h12);
      wr(IDX_CNT_LO, 8'h34);
      wr(IDX_MMODE[2], 8'h20);
      module_pin_i[2] <= 1'b1;
      waitc(3);
      rc("capture flag", IDX_CTRL, 8'h04);
      chk("irq gated", 16'h0000, {15'h0, irq_o});
      rc("capture lo", IDX_MLO[2], 8'h34);
      rc("capture hi", IDX_MHI[2], 8'h12);
      wr(IDX_MMODE[1], 8'h11);
      module_pin_i[1] <= 1'b1;
      waitc(3);
      rc("no rise capture", IDX_CTRL, 8'h04);
      module_pin_i[1] <= 1'b0;
      waitc(3);
      rc("fall capture", IDX_CTRL, 8'h06);
      chk("module irq", 16'h0001, {15'h0, irq_o});
      wr(IDX_CTRL, 8'h00);
      waitc(2);
      chk("irq cleared", 16'h0000, {15'h0, irq_o});
      tend("capture");
      wr(IDX_MMODE[1], 8'h44);
      wr(IDX_MLO[1], 8'h10);
      wr(IDX_MHI[1], 8'h00);
      wr(IDX_MMODE[0], 8'h49);
      wr(IDX_MLO[0], 8'h20);
      rc("lo clears ecom", IDX_MMODE[0], 8'h09);
      wr(IDX_MHI[0], 8'h00);
      rc("hi sets ecom", IDX_MMODE[0], 8'h49);
      wr(IDX_CNT_HI, 8'h00);
      wr(IDX_CNT_LO, 8'h00);
      wr(IDX_CTRL, 8'h40);
      waitc(40);
      rc("match flag", IDX_CTRL, 8'h41);
      chk("match irq", 16'h0001, {15'h0, irq_o});
      chk("toggle pin", 16'h0001, {15'h0, module_pin_o[1]});
      wr(IDX_CTRL, 8'h00);
      tend("match");
      for (int w = 0; w < 2; w++) begin
         wr(IDX_MMODE[0], w ? 8'hC2 : 8'h42);
         wr(IDX_MLO[0], w ? 8'h80 : 8'hC0);
         wr(IDX_MHI[0], w ? 8'hFF : 8'hC0);
         wr(IDX_CNT_HI, w ? 8'hFF : 8'h00);
         wr(IDX_CNT_LO, 8'h00);
         wr(IDX_CTRL, 8'h40);
         n = 0;
         repeat (256) begin
            @(posedge core_clk_i);
            if (module_pin_o[0] === 1'b1) n++;
         end
         wr(IDX_CTRL, 8'h00);
         rng("pwm high time", w ? 124 : 60, w ? 132 : 68, n[15:0]);
      end
      tend("pwm");
      wr(IDX_MLO[2], 8'h02);
      wr(IDX_MODE, 8'h40);
      wr(IDX_MODE, 8'h48);
      rc("mode blocked", IDX_MODE, 8'h40);
      bus(1'b0, IDX_CNT_HI, 8'h00);
      hv = rdv;
      wr(IDX_MHI[2], 8'h00);
      rc("wd reload", IDX_MHI[2], hv + 8'h02);
      n = 0;
      // Offset 2 fires at the third low-byte overflow: about 256 * 3 ticks of 12 clocks.
      while (wdt_reset_o !== 1'b1 && n < 9500) begin
         @(posedge core_clk_i);
         n++;
      end
      rng("wd fire time", 12 * (768 - 16), 12 * 768, n[15:0]);
      wr(IDX_MODE, 8'h60);
      wr(IDX_MODE, 8'h00);
      rc("wd locked", IDX_MODE, 8'h60);
      tend("watchdog");
      final_report;
   end
endmodule
